//--- test/board_model.sv
`timescale 1ns/100ps
module board_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull_en,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  logic [7:0] float_reg = 8'h55;
  // Floating lines toggle on every clock, so a stale level does not hold steady on them
  always_ff @(posedge i_sys_clk) float_reg <= ~float_reg;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      o_level[n] = i_oe[n] ? i_out[n] : i_ext_en[n] ? i_ext_val[n] : i_pull_en[n] ? 1'b1 : float_reg[n];
    end
  end
endmodule

//--- test/nibble_and_fixed_io_ports_bench.sv
`timescale 1ns/100ps
module nibble_and_fixed_io_ports_bench;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lines, pin_out, pin_oe, pull_en, rdata;
  logic       wr = 1'b0, rd = 1'b0, stop_mode_recovery = 1'b0;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
  logic [3:0] fixed_in = 4'h0, timer = 4'h0, fixed_out, irq;
  int         fail_count = 0;
  int         samples_checked = 0;
  nibble_and_fixed_io_ports uut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_stop_mode_recovery(stop_mode_recovery), .i_nibble_port_lines(lines),
    .o_nibble_port_lines(pin_out), .o_nibble_port_oe(pin_oe), .o_nibble_pull_en(pull_en),
    .i_fixed_input_lines(fixed_in), .o_fixed_output_lines(fixed_out), .o_fixed_irq_lines(irq), .i_timer_out(timer));
  board_model board (.i_sys_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .i_pull_en(pull_en), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(lines));
  initial begin
    forever #5 clk = ~clk;
  end
  // ********************************
  // Bus and compare tasks
  // ********************************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    chk("oe after reset", 8'h00, pin_oe);
    chk("pull after reset", 8'hFF, pull_en);
  endtask
  task automatic t_dir();
    ext_en <= 8'hF0; ext_val <= 8'hC0;
    bus_wr(port_io_pkg::NIBBLE_MODE_ADDR, 8'h02);
    bus_wr(port_io_pkg::NIBBLE_DATA_ADDR, 8'hA5);
    settle(3);
    chk("oe low out", 8'h0F, pin_oe);
    chk("out low", 8'h05, pin_out & 8'h0F);
    chk("pull low out", 8'hF0, pull_en);
    bus_rd("nibble data", port_io_pkg::NIBBLE_DATA_ADDR, 8'hC5);
    bus_rd("mode read", port_io_pkg::NIBBLE_MODE_ADDR, 8'h00);
    bus_rd("unmapped", 8'h77, 8'h00);
    ext_en <= 8'h0F; ext_val <= 8'h03;
    bus_wr(port_io_pkg::NIBBLE_MODE_ADDR, 8'h01);
    settle(3);
    chk("oe high out", 8'hF0, pin_oe);
    chk("pull high out", 8'h0F, pull_en);
    bus_rd("nibble data hi", port_io_pkg::NIBBLE_DATA_ADDR, 8'hA3);
  endtask
  task automatic t_open_drain();
    ext_en <= 8'h00;
    bus_wr(port_io_pkg::NIBBLE_MODE_ADDR, 8'h00);
    bus_wr(port_io_pkg::PORT_CONFIG_ADDR, 8'h04);
    settle(3);
    chk("oe open drain", 8'h5A, pin_oe);
    chk("out open drain", 8'h00, pin_out);
    chk("pull both out", 8'h00, pull_en);
    bus_rd("config read", port_io_pkg::PORT_CONFIG_ADDR, 8'h00);
    bus_wr(port_io_pkg::PORT_CONFIG_ADDR, 8'h00);
    settle(3);
    chk("oe push pull", 8'hFF, pin_oe);
    chk("out push pull", 8'hA5, pin_out);
  endtask
  task automatic t_recovery();
    @(posedge clk);
    stop_mode_recovery <= 1'b1;
    @(posedge clk);
    stop_mode_recovery <= 1'b0;
    settle(5);
    chk("oe after recovery", 8'h00, pin_oe);
    chk("pull after recovery", 8'hFF, pull_en);
  endtask
  task automatic t_hw_reset();
    bus_wr(port_io_pkg::NIBBLE_MODE_ADDR, 8'h00);
    settle(3);
    chk("oe before reset", 8'hFF, pin_oe);
    @(posedge clk);
    arst_n <= 1'b0;
    settle(2);
    chk("oe in reset", 8'h00, pin_oe);
    chk("pull in reset", 8'hFF, pull_en);
    @(posedge clk);
    arst_n <= 1'b1;
    settle(1);
    t_reset();
  endtask
  task automatic t_fixed();
    fixed_in <= 4'hA; timer <= 4'h6;
    bus_wr(port_io_pkg::FIXED_DATA_ADDR, 8'h50);
    settle(3);
    chk("irq lines", 8'h0A, {4'h0, irq});
    chk("fixed out", 8'h05, {4'h0, fixed_out});
    bus_rd("fixed read", port_io_pkg::FIXED_DATA_ADDR, 8'h5A);
    bus_wr(port_io_pkg::FIXED_SEL_ADDR, 8'h03);
    settle(3);
    chk("fixed timer mix", 8'h06, {4'h0, fixed_out});
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    settle(1);
    t_reset();
    t_dir();
    t_open_drain();
    t_recovery();
    t_hw_reset();
    t_fixed();
    test_done();
  end
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
endmodule

//--- verilog/nibble_and_fixed_io_ports.sv
`timescale 1ns/100ps
// Notes on behaviour
// - The eight nibble port lines have separate direction control for the low and high nibble.
// - One bit of the port configuration register picks push-pull or open-drain drive.
// - A hardware reset puts all nibble port lines into input direction.
// - A stop-mode recovery also returns the nibble port direction to input.
// - The pull-up of any nibble line programmed as output is switched off.
// - The fixed port has four input-only lines and four push-pull output-only lines.
// - Fixed inputs can feed interrupt logic and fixed outputs can carry timer signals.
module nibble_and_fixed_io_ports (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_stop_mode_recovery,
  input  wire logic [7:0] i_nibble_port_lines,
  output logic      [7:0] o_nibble_port_lines,
  output logic      [7:0] o_nibble_port_oe,
  output logic      [7:0] o_nibble_pull_en,
  input  wire logic [3:0] i_fixed_input_lines,
  output logic      [3:0] o_fixed_output_lines,
  output logic      [3:0] o_fixed_irq_lines,
  input  wire logic [3:0] i_timer_out
);

  // ********************************
  // Input synchronisers
  // ********************************
  logic [7:0] nib_meta_reg;
  logic [7:0] nib_sync_reg;
  logic [3:0] fix_meta_reg;
  logic [3:0] fix_sync_reg;
  logic       smr_meta_reg;
  logic       smr_sync_reg;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nib_meta_reg <= 8'h00;
      nib_sync_reg <= 8'h00;
      fix_meta_reg <= 4'h0;
      fix_sync_reg <= 4'h0;
      smr_meta_reg <= 1'b0;
      smr_sync_reg <= 1'b0;
    end else begin
      nib_meta_reg <= i_nibble_port_lines;
      nib_sync_reg <= nib_meta_reg;
      fix_meta_reg <= i_fixed_input_lines;
      fix_sync_reg <= fix_meta_reg;
      smr_meta_reg <= i_stop_mode_recovery;
      smr_sync_reg <= smr_meta_reg;
    end
  end

  // ********************************
  // Register decode
  // ********************************
  port_io_pkg::reg_req_type req;
  assign req.wr    = i_wr;
  assign req.rd    = i_rd;
  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;

  wire wr_cfg   = req.wr && (req.addr == port_io_pkg::PORT_CONFIG_ADDR);
  wire wr_mode  = req.wr && (req.addr == port_io_pkg::NIBBLE_MODE_ADDR);
  wire wr_ndata = req.wr && (req.addr == port_io_pkg::NIBBLE_DATA_ADDR);
  wire wr_fdata = req.wr && (req.addr == port_io_pkg::FIXED_DATA_ADDR);
  wire wr_fsel  = req.wr && (req.addr == port_io_pkg::FIXED_SEL_ADDR);

  logic [7:0] port_config_reg;
  logic [1:0] dir_in_reg;
  logic [7:0] nib_data_reg;
  logic [3:0] fix_data_reg;
  logic [3:0] fix_sel_reg;

  // Recovery wins over a same-cycle mode write so the port always wakes as input
  wire [1:0] dir_in_next = smr_sync_reg ? port_io_pkg::NIBBLE_MODE_RST :
                           wr_mode ? {req.wdata[port_io_pkg::HI_DIR_BIT],
                                      req.wdata[port_io_pkg::LO_DIR_BIT]} : dir_in_reg;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_config_reg <= port_io_pkg::PORT_CONFIG_RST;
      dir_in_reg      <= port_io_pkg::NIBBLE_MODE_RST;
      nib_data_reg    <= port_io_pkg::NIBBLE_DATA_RST;
      fix_data_reg    <= port_io_pkg::FIXED_DATA_RST;
      fix_sel_reg     <= port_io_pkg::FIXED_SEL_RST;
    end else begin
      dir_in_reg <= dir_in_next;
      if (wr_cfg) begin
        port_config_reg <= req.wdata;
      end
      if (wr_ndata) begin
        nib_data_reg <= req.wdata;
      end
      if (wr_fdata) begin
        fix_data_reg <= req.wdata[7:4];
      end
      if (wr_fsel) begin
        fix_sel_reg <= req.wdata[3:0];
      end
    end
  end

  // ********************************
  // Read path
  // ********************************
  // Mode and config are write-only; input lines read back per nibble direction
  wire [7:0] nib_read = {dir_in_reg[1] ? nib_sync_reg[7:4] : nib_data_reg[7:4],
                         dir_in_reg[0] ? nib_sync_reg[3:0] : nib_data_reg[3:0]};
  wire [7:0] fix_read = {fix_data_reg, fix_sync_reg};
  wire [7:0] rd_mux   = !req.rd ? port_io_pkg::READ_ZERO :
                        (req.addr == port_io_pkg::NIBBLE_DATA_ADDR) ? nib_read :
                        (req.addr == port_io_pkg::FIXED_DATA_ADDR) ? fix_read :
                        (req.addr == port_io_pkg::FIXED_SEL_ADDR) ? {4'h0, fix_sel_reg} :
                        port_io_pkg::READ_ZERO;

  // ********************************
  // Pin drive
  // ********************************
  port_io_pkg::pin_drive_type drive;

  nibble_pin_drive u_drive (
    .i_open_drain (port_config_reg[port_io_pkg::OPEN_DRAIN_BIT]),
    .i_dir_in     (dir_in_reg),
    .i_data       (nib_data_reg),
    .o_drive      (drive)
  );

  // Timer select replaces register bit per output line
  wire [3:0] fix_out_next = (fix_sel_reg & i_timer_out) | (~fix_sel_reg & fix_data_reg);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata              <= 8'h00;
      o_nibble_port_lines  <= 8'h00;
      o_nibble_port_oe     <= 8'h00;
      o_nibble_pull_en     <= 8'hFF;
      o_fixed_output_lines <= 4'h0;
      o_fixed_irq_lines    <= 4'h0;
    end else begin
      o_rdata              <= rd_mux;
      o_nibble_port_lines  <= drive.out;
      o_nibble_port_oe     <= drive.oe;
      o_nibble_pull_en     <= drive.pull_en;
      o_fixed_output_lines <= fix_out_next;
      o_fixed_irq_lines    <= fix_sync_reg;
    end
  end

  // ********************************
  // Checks
  // ********************************
  AST_RESET_INPUT: assert property (@(posedge i_sys_clk) $rose(i_arst_n) |-> o_nibble_port_oe == 8'h00)
    else $error("Nibble port driving after reset");
  AST_SMR_INPUT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    smr_sync_reg |=> ##1 o_nibble_port_oe == 8'h00)
    else $error("Nibble port not input after recovery");
  AST_SMR_DIR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    smr_sync_reg |=> dir_in_reg == port_io_pkg::NIBBLE_MODE_RST)
    else $error("Direction not input after recovery");
  AST_PULL_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_nibble_port_oe & o_nibble_pull_en) == 8'h00)
    else $error("Pull-up on while driving");
  AST_PULL_DIR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    ##1 o_nibble_pull_en == {{4{$past(dir_in_reg[1])}}, {4{$past(dir_in_reg[0])}}})
    else $error("Pull-up does not follow direction");
  AST_LO_NIBBLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_mode && !smr_sync_reg && !i_wdata[0] && !i_wdata[2] |=> ##1 o_nibble_pull_en[3:0] == 4'h0)
    else $error("Low nibble not output");
  AST_HI_NIBBLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_mode && !smr_sync_reg && i_wdata[1] |=> ##1 o_nibble_port_oe[7:4] == 4'h0)
    else $error("High nibble not input");
  // Read checks look one cycle after the strobe, the only cycle the data stands
  AST_LO_READ: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    req.rd && req.addr == port_io_pkg::NIBBLE_DATA_ADDR && dir_in_reg[0]
    |=> o_rdata[3:0] == $past(nib_sync_reg[3:0]))
    else $error("Low input nibble read wrong");
  AST_HI_READ: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    req.rd && req.addr == port_io_pkg::NIBBLE_DATA_ADDR && dir_in_reg[1]
    |=> o_rdata[7:4] == $past(nib_sync_reg[7:4]))
    else $error("High input nibble read wrong");
  AST_WRITE_ONLY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    req.rd && (req.addr == port_io_pkg::NIBBLE_MODE_ADDR || req.addr == port_io_pkg::PORT_CONFIG_ADDR)
    |=> o_rdata == port_io_pkg::READ_ZERO)
    else $error("Write-only register read nonzero");
  AST_OPEN_DRAIN: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    port_config_reg[port_io_pkg::OPEN_DRAIN_BIT] |=> (o_nibble_port_lines == 8'h00))
    else $error("Open drain drove high");
  AST_OD_ONES: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    port_config_reg[port_io_pkg::OPEN_DRAIN_BIT] |=> (o_nibble_port_oe & $past(nib_data_reg)) == 8'h00)
    else $error("Open drain enabled on a one");
  AST_OUT_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !port_config_reg[port_io_pkg::OPEN_DRAIN_BIT] |=> o_nibble_port_lines == $past(nib_data_reg))
    else $error("Push-pull value mismatch");
  AST_PUSH_PULL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !port_config_reg[port_io_pkg::OPEN_DRAIN_BIT] && dir_in_reg == 2'h0 |=> o_nibble_port_oe == 8'hFF)
    else $error("Push-pull output not driving");
  AST_FIXED_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    fix_sel_reg == 4'h0 && $stable(fix_sel_reg) |=> o_fixed_output_lines == $past(fix_data_reg))
    else $error("Fixed output mismatch");
  AST_FIX_READ: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    req.rd && req.addr == port_io_pkg::FIXED_DATA_ADDR
    |=> o_rdata == {$past(fix_data_reg), $past(fix_sync_reg)})
    else $error("Fixed port read wrong");
  AST_TIMER_SEL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    ##1 ((o_fixed_output_lines ^ $past(i_timer_out)) & $past(fix_sel_reg)) == 4'h0)
    else $error("Timer signal not on selected line");
  AST_IRQ_ROUTE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    ##3 o_fixed_irq_lines == $past(i_fixed_input_lines, 3))
    else $error("Interrupt route mismatch");

  // ********************************
  // Coverage
  // ********************************
  COV_OUT_MODE: cover property (@(posedge i_sys_clk) o_nibble_port_oe == 8'hFF);
  COV_SMR: cover property (@(posedge i_sys_clk) smr_sync_reg && dir_in_reg != 2'h3);
  COV_TIMER: cover property (@(posedge i_sys_clk) fix_sel_reg != 4'h0);
  COV_OPEN_DRAIN: cover property (@(posedge i_sys_clk) port_config_reg[port_io_pkg::OPEN_DRAIN_BIT] && o_nibble_port_oe != 8'h00);
  COV_SPLIT_DIR: cover property (@(posedge i_sys_clk) o_nibble_port_oe == 8'h0F);

endmodule

//--- verilog/nibble_pin_drive.sv
`timescale 1ns/100ps
module nibble_pin_drive (
  input  wire logic       i_open_drain,
  input  wire logic [1:0] i_dir_in,
  input  wire logic [7:0] i_data,
  output port_io_pkg::pin_drive_type o_drive
);

  // ********************************
  // Per-nibble driver selection
  // ********************************
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_line
      wire is_out = ~i_dir_in[g / 4];
      // Open drain only sinks: enable while driving a zero
      assign o_drive.oe[g]      = is_out & (~i_open_drain | ~i_data[g]);
      assign o_drive.out[g]     = i_data[g] & ~i_open_drain;
      assign o_drive.pull_en[g] = ~is_out;
    end
  endgenerate

endmodule

//--- verilog/port_io_pkg.sv
package port_io_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] PORT_CONFIG_ADDR  = 8'h00;
  localparam logic [7:0] NIBBLE_MODE_ADDR  = 8'h01;
  localparam logic [7:0] NIBBLE_DATA_ADDR  = 8'h02;
  localparam logic [7:0] FIXED_DATA_ADDR   = 8'h03;
  localparam logic [7:0] FIXED_SEL_ADDR    = 8'h04;

  // ********************************
  // Field positions
  // ********************************
  localparam int OPEN_DRAIN_BIT = 2;
  localparam int LO_DIR_BIT     = 0;
  localparam int HI_DIR_BIT     = 1;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] PORT_CONFIG_RST = 8'h00;
  localparam logic [1:0] NIBBLE_MODE_RST = 2'h3;
  localparam logic [7:0] NIBBLE_DATA_RST = 8'h00;
  localparam logic [3:0] FIXED_DATA_RST  = 4'h0;
  localparam logic [3:0] FIXED_SEL_RST   = 4'h0;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } pin_drive_type;

endpackage
